/* File: hdl/smpp_pkg.sv */
// constants, opcodes and types of the serial memory programming port
// assumes a 10 MHz hclk and a programmer driving the link pins
package smpp_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_STATUS     = 8'h04;
    localparam int         CTRL_SERIAL_POS = 0;
    // instruction first bytes and patterns
    localparam logic [7:0] OPC_ENTER    = 8'hAC;
    localparam logic [7:0] OPC_ENABLE   = 8'h53;
    localparam logic [2:0] ERASE_PAT    = 3'h4;
    localparam logic [4:0] LOCK_PAT     = 5'h1F;
    localparam logic [3:0] FUSE_PAT     = 4'hB;
    localparam logic [7:0] OPC_RD_FLASH = 8'h20;
    localparam logic [7:0] OPC_LD_PAGE  = 8'h40;
    localparam logic [7:0] OPC_WR_PAGE  = 8'h4C;
    localparam logic [7:0] OPC_RD_EE    = 8'hA0;
    localparam logic [7:0] OPC_WR_EE    = 8'hC0;
    localparam logic [7:0] OPC_RD_LOCK  = 8'h58;
    localparam logic [7:0] OPC_RD_FUSE  = 8'h50;
    localparam logic [7:0] OPC_RD_SIG   = 8'h30;
    localparam logic [7:0] H_MASK       = 8'h08;
    localparam int         H_POS        = 3;
    // field positions inside instruction and answer bytes
    localparam int LOCK1_POS  = 1;
    localparam int LOCK2_POS  = 2;
    localparam int SERIAL_POS = 5;
    localparam int KEEP_POS   = 3;
    localparam int SUT_HI_POS = 1;
    localparam int SUT_LO_POS = 0;
    localparam int PAGE_POS   = 7;
    // bit counter marks
    localparam logic [4:0] CNT_B3_LAST  = 5'h17;
    localparam logic [4:0] CNT_B4_FIRST = 5'h18;
    localparam logic [4:0] CNT_LAST     = 5'h1F;
    // reset values and fixed answers
    localparam logic       LOCK_RST     = 1'b1;
    localparam logic       KEEP_RST     = 1'b1;
    localparam logic [1:0] SUT_RST      = 2'h3;
    localparam logic       SERIAL_RST   = 1'b0;
    localparam logic [7:0] VERIFY_BLANK = 8'hFF;
    localparam logic [7:0] BYTE_ONES    = 8'hFF;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    // link state, gray coded along off, wait, programming
    typedef enum logic [1:0] {
        LK_OFF  = 2'h0,
        LK_WAIT = 2'h1,
        LK_PROG = 2'h3
    } smpp_link_t;
    // operations sent to the memory arrays
    typedef enum logic [2:0] {
        MEM_NONE        = 3'h0,
        MEM_RD_FLASH    = 3'h1,
        MEM_LD_PAGE     = 3'h2,
        MEM_WR_PAGE     = 3'h3,
        MEM_RD_EE       = 3'h4,
        MEM_WR_EE       = 3'h5,
        MEM_ERASE_ALL   = 3'h6,
        MEM_ERASE_FLASH = 3'h7
    } smpp_mem_op_t;
endpackage : smpp_pkg

/* File: hdl/smpp_top.sv */
// serial memory programming port: link decoder, protection, fuses, ahb-lite slave
// assumes link pins are asynchronous to hclk and memories answer one cycle after a strobe
`timescale 1ns/1ps
`default_nettype none
module smpp_top #(
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE1 = 8'hA5, // arbitrary identity value
    parameter logic [7:0] SIG_BYTE2 = 8'h3C  // arbitrary identity value
) (
    // clock, reset, enable
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  ce,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // programming link pins
    input  wire logic                  prog_sck,
    input  wire logic                  prog_reset_n,
    input  wire logic                  prog_data_in,
    output logic                       prog_data_out,
    output logic                       prog_data_oe,
    // memory array side
    output logic                       mem_strobe,
    output smpp_pkg::smpp_mem_op_t     mem_op,
    output logic      [15:0]           mem_addr,
    output logic                       mem_hi,
    output logic      [7:0]            mem_wdata,
    input  wire logic [7:0]            mem_rdata,
    // fuse outputs
    output logic      [1:0]            startup_delay_fuses
);
    import smpp_pkg::*;

    logic         sck_s1_reg, sck_s2_reg, sck_d_reg;
    logic         din_s1_reg, din_s2_reg;
    logic         rst_s1_reg, rst_s2_reg;
    logic         sck_rise, sck_fall, link_off;
    smpp_link_t   state_reg;
    logic [31:0]  sh_reg;
    logic [4:0]   cnt_reg;
    logic         at24_reg, at32_reg;
    logic         protect_bit_one_reg, protect_bit_two_reg;
    logic         eeprom_keep_fuse_reg, serial_load_enable_fuse_reg;
    logic [1:0]   startup_delay_fuses_reg;
    logic         mem_strobe_reg, mem_hi_reg;
    smpp_mem_op_t mem_op_reg;
    logic [15:0]  mem_addr_reg;
    logic [7:0]   mem_wdata_reg;
    logic         rd_wait_reg, rd_take_reg;
    logic [7:0]   out_sh_reg;
    logic         pdo_reg, pdo_oe_reg;
    logic [31:0]  hrdata_reg;
    logic         hreadyout_reg, hresp_reg;
    logic         wr_pend_reg;
    logic [7:0]   wr_addr_reg;
    logic [7:0]   b1, b2, b3, b4, r1, r3;
    logic [15:0]  r23;
    logic         prog_ok, wr_allowed, verify_ok;
    logic         is_enable, is_erase, is_wlock, is_wfuse;
    logic         is_wpage, is_ldpage, is_wee;
    logic         rd_flash, rd_ee, rd_lock, rd_fuse, rd_sig;
    logic [7:0]   lock_byte, fuse_byte, sig_byte;
    logic [31:0]  status_word;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn || !ce);

    // two-stage synchronisers for the link pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_d_reg  <= 1'b0;
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= 1'b1;
        end else if (ce) begin
            sck_s1_reg <= prog_sck;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg  <= sck_s2_reg;
            din_s1_reg <= prog_data_in;
            din_s2_reg <= din_s1_reg;
            rst_s1_reg <= prog_reset_n;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // link edges; link idles while reset is high or the enable fuse is 1
    assign sck_rise = sck_s2_reg & ~sck_d_reg;
    assign sck_fall = ~sck_s2_reg & sck_d_reg;
    assign link_off = rst_s2_reg | serial_load_enable_fuse_reg;

    // instruction bytes after 32 bits and after 24 bits
    assign b1  = sh_reg[31:24];
    assign b2  = sh_reg[23:16];
    assign b3  = sh_reg[15:8];
    assign b4  = sh_reg[7:0];
    assign r1  = sh_reg[23:16];
    assign r23 = sh_reg[15:0];
    assign r3  = sh_reg[7:0];

    // decode only fixed and field bits, don't-care bits unread
    assign is_enable = (b1 == OPC_ENTER) && (b2 == OPC_ENABLE);
    assign is_erase  = (b1 == OPC_ENTER) && (b2[7:5] == ERASE_PAT);
    assign is_wlock  = (b1 == OPC_ENTER) && (b2[7:3] == LOCK_PAT) && b2[0];
    assign is_wfuse  = (b1 == OPC_ENTER) && (b2[7:4] == FUSE_PAT);
    assign is_wpage  = (b1 == OPC_WR_PAGE);
    assign is_ldpage = ((b1 & ~H_MASK) == OPC_LD_PAGE);
    assign is_wee    = (b1 == OPC_WR_EE);
    assign rd_flash  = ((r1 & ~H_MASK) == OPC_RD_FLASH);
    assign rd_ee     = (r1 == OPC_RD_EE);
    assign rd_lock   = (r1 == OPC_RD_LOCK);
    assign rd_fuse   = (r1 == OPC_RD_FUSE);
    assign rd_sig    = (r1 == OPC_RD_SIG);

    // protection modes
    assign prog_ok    = (state_reg == LK_PROG) && !link_off;
    assign wr_allowed = protect_bit_one_reg;
    assign verify_ok  = protect_bit_one_reg | protect_bit_two_reg;

    // answer bytes for lock, fuse and identity reads
    always_comb begin
        lock_byte = BYTE_ONES;
        lock_byte[LOCK1_POS] = protect_bit_one_reg;
        lock_byte[LOCK2_POS] = protect_bit_two_reg;
        fuse_byte = BYTE_ONES;
        fuse_byte[SERIAL_POS] = SERIAL_RST;           // link is alive only at 0
        fuse_byte[KEEP_POS]   = eeprom_keep_fuse_reg;
        fuse_byte[SUT_HI_POS] = startup_delay_fuses_reg[1];
        fuse_byte[SUT_LO_POS] = startup_delay_fuses_reg[0];
        case (r3[1:0])
            2'h0:    sig_byte = SIG_BYTE0;
            2'h1:    sig_byte = SIG_BYTE1;
            2'h2:    sig_byte = SIG_BYTE2;
            default: sig_byte = BYTE_ZERO;
        endcase
    end

    // link state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= LK_OFF;
        end else if (ce) begin
            if (link_off) begin
                state_reg <= LK_OFF;
            end else begin
                case (state_reg)
                    LK_OFF:  state_reg <= LK_WAIT;
                    LK_WAIT: if (at32_reg && is_enable) state_reg <= LK_PROG;
                    LK_PROG: state_reg <= LK_PROG;
                    default: state_reg <= LK_OFF;
                endcase
            end
        end
    end

    enable_enter_a: assert property ((at32_reg && state_reg == LK_WAIT && is_enable && !link_off)
        |=> state_reg == LK_PROG) else $error("enable instruction not taken");
    serial_gate_a: assert property (serial_load_enable_fuse_reg |=> state_reg == LK_OFF)
        else $error("link active with serial fuse unprogrammed");

    // input shift register and bit counter, msb first on rising sck
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sh_reg   <= '0;
            cnt_reg  <= '0;
            at24_reg <= 1'b0;
            at32_reg <= 1'b0;
        end else if (ce) begin
            at24_reg <= !link_off && sck_rise && (cnt_reg == CNT_B3_LAST);
            at32_reg <= !link_off && sck_rise && (cnt_reg == CNT_LAST);
            if (link_off) begin
                sh_reg  <= '0;
                cnt_reg <= '0;
            end else if (sck_rise) begin
                sh_reg  <= {sh_reg[30:0], din_s2_reg};
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // protection bits: erase restores, lock write only programs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            protect_bit_one_reg <= LOCK_RST;
            protect_bit_two_reg <= LOCK_RST;
        end else if (ce && at32_reg && prog_ok) begin
            if (is_erase) begin
                protect_bit_one_reg <= LOCK_RST;
                protect_bit_two_reg <= LOCK_RST;
            end else if (is_wlock) begin
                protect_bit_one_reg <= protect_bit_one_reg & b2[LOCK1_POS];
                protect_bit_two_reg <= protect_bit_two_reg & b2[LOCK2_POS];
            end
        end
    end

    lock_erase_a: assert property ((at32_reg && prog_ok && is_erase)
        |=> (protect_bit_one_reg && protect_bit_two_reg)) else $error("erase kept locks");

    // fuses: serial write ignores locks except keep fuse; erase leaves them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eeprom_keep_fuse_reg    <= KEEP_RST;
            startup_delay_fuses_reg <= SUT_RST;
        end else if (ce && at32_reg && prog_ok && is_wfuse) begin
            startup_delay_fuses_reg <= {b2[SUT_HI_POS], b2[SUT_LO_POS]};
            if (b2[KEEP_POS] || (protect_bit_one_reg && protect_bit_two_reg)) begin
                eeprom_keep_fuse_reg <= b2[KEEP_POS];
            end
        end
    end

    keep_fuse_a: assert property ($fell(eeprom_keep_fuse_reg)
        |-> $past(protect_bit_one_reg && protect_bit_two_reg))
        else $error("keep fuse programmed under lock");
    fuse_hold_a: assert property ((at32_reg && is_erase)
        |=> ($stable(startup_delay_fuses_reg) && $stable(eeprom_keep_fuse_reg)))
        else $error("erase changed a fuse");

    // memory requests: reads after byte three, writes after byte four
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_strobe_reg <= 1'b0;
            mem_op_reg     <= MEM_NONE;
            mem_addr_reg   <= '0;
            mem_hi_reg     <= 1'b0;
            mem_wdata_reg  <= '0;
            rd_wait_reg    <= 1'b0;
            rd_take_reg    <= 1'b0;
        end else if (ce) begin
            mem_strobe_reg <= 1'b0;
            rd_take_reg    <= rd_wait_reg;
            rd_wait_reg    <= 1'b0;
            if (at24_reg && prog_ok && (rd_flash || rd_ee) && verify_ok) begin
                mem_strobe_reg <= 1'b1;
                rd_wait_reg    <= 1'b1;
                mem_op_reg     <= rd_flash ? MEM_RD_FLASH : MEM_RD_EE;
                mem_hi_reg     <= r1[H_POS];
                mem_addr_reg   <= rd_flash ? r23 : {4'h0, r23[11:0]};
            end else if (at32_reg && prog_ok) begin
                if (is_erase) begin
                    mem_strobe_reg <= 1'b1;
                    mem_op_reg <= eeprom_keep_fuse_reg ? MEM_ERASE_ALL : MEM_ERASE_FLASH;
                end else if (is_wpage && wr_allowed) begin
                    mem_strobe_reg <= 1'b1;
                    mem_op_reg     <= MEM_WR_PAGE;
                    mem_addr_reg   <= {b2, b3[PAGE_POS], 7'h00};
                end else if (is_ldpage) begin
                    mem_strobe_reg <= 1'b1;
                    mem_op_reg     <= MEM_LD_PAGE;
                    mem_hi_reg     <= b1[H_POS];
                    mem_addr_reg   <= {9'h000, b3[6:0]};
                    mem_wdata_reg  <= b4;
                end else if (is_wee && wr_allowed) begin
                    mem_strobe_reg <= 1'b1;
                    mem_op_reg     <= MEM_WR_EE;
                    mem_addr_reg   <= {4'h0, b2[3:0], b3};
                    mem_wdata_reg  <= b4;
                end
            end
        end
    end

    mode_two_a: assert property ((mem_strobe_reg
        && (mem_op_reg == MEM_WR_PAGE || mem_op_reg == MEM_WR_EE)) |-> protect_bit_one_reg)
        else $error("write issued while locked");
    erase_keep_a: assert property ((at32_reg && prog_ok && is_erase && !eeprom_keep_fuse_reg)
        |=> (mem_strobe_reg && mem_op_reg == MEM_ERASE_FLASH))
        else $error("erase touched kept eeprom");

    // output byte: loaded after byte three, shifted on falling sck in byte four
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_sh_reg <= '0;
            pdo_reg    <= 1'b0;
            pdo_oe_reg <= 1'b0;
        end else if (ce) begin
            pdo_oe_reg <= !link_off;
            if (link_off) begin
                out_sh_reg <= '0;
                pdo_reg    <= 1'b0;
            end else if (at24_reg) begin
                if (!prog_ok) out_sh_reg <= BYTE_ZERO;
                else if (rd_lock) out_sh_reg <= lock_byte;
                else if (rd_fuse) out_sh_reg <= fuse_byte;
                else if (rd_sig) out_sh_reg <= sig_byte;
                else if ((rd_flash || rd_ee) && !verify_ok) out_sh_reg <= VERIFY_BLANK;
                else out_sh_reg <= BYTE_ZERO;
            end else if (rd_take_reg) begin
                out_sh_reg <= mem_rdata;
            end else if (sck_fall) begin
                if (cnt_reg >= CNT_B4_FIRST) begin
                    pdo_reg    <= out_sh_reg[7];
                    out_sh_reg <= {out_sh_reg[6:0], 1'b0};
                end else begin
                    pdo_reg <= 1'b0;
                end
            end
        end
    end

    verify_block_a: assert property ((at24_reg && prog_ok && (rd_flash || rd_ee) && !verify_ok)
        |=> (out_sh_reg == VERIFY_BLANK && !mem_strobe_reg))
        else $error("verify read not blocked");
    lock_read_a: assert property ((at24_reg && prog_ok && rd_lock)
        |=> (out_sh_reg[LOCK1_POS] == $past(protect_bit_one_reg)
             && out_sh_reg[LOCK2_POS] == $past(protect_bit_two_reg)))
        else $error("lock read wrong");

    // status word: serial fuse, startup, keep, locks, link state
    assign status_word = {24'h000000, serial_load_enable_fuse_reg, startup_delay_fuses_reg,
                          eeprom_keep_fuse_reg, protect_bit_two_reg, protect_bit_one_reg,
                          state_reg};

    // ahb-lite slave, zero wait states, always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg    <= '0;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= '0;
        end else if (ce) begin
            if (hready) begin
                wr_pend_reg <= hsel && htrans[1] && hwrite;
                wr_addr_reg <= haddr[7:0];
                if (hsel && htrans[1] && !hwrite) begin
                    case (haddr[7:0])
                        ADDR_CTRL:   hrdata_reg <= 32'(serial_load_enable_fuse_reg);
                        ADDR_STATUS: hrdata_reg <= status_word;
                        default:     hrdata_reg <= '0;
                    endcase
                end
            end
        end
    end

    // control register: serial load enable fuse, reachable from software only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            serial_load_enable_fuse_reg <= SERIAL_RST;
        end else if (ce && wr_pend_reg && wr_addr_reg == ADDR_CTRL) begin
            serial_load_enable_fuse_reg <= hwdata[CTRL_SERIAL_POS];
        end
    end

    // the link has no path to the serial enable fuse; only a software write moves it
    serial_fixed_a: assert property (!(wr_pend_reg && wr_addr_reg == ADDR_CTRL)
        |=> $stable(serial_load_enable_fuse_reg))
        else $error("serial fuse changed outside software write");

    // outputs straight from flip-flops
    assign hrdata              = hrdata_reg;
    assign hreadyout           = hreadyout_reg;
    assign hresp               = hresp_reg;
    assign prog_data_out       = pdo_reg;
    assign prog_data_oe        = pdo_oe_reg;
    assign mem_strobe          = mem_strobe_reg;
    assign mem_op              = mem_op_reg;
    assign mem_addr            = mem_addr_reg;
    assign mem_hi              = mem_hi_reg;
    assign mem_wdata           = mem_wdata_reg;
    assign startup_delay_fuses = startup_delay_fuses_reg;

endmodule : smpp_top
`default_nettype wire

/* File: tb/smpp_prog_model.sv */
// programmer model: shifts 32-bit instructions onto the link msb first
// assumes 10 MHz hclk; link clock period is eight hclk cycles
`timescale 1ns/1ps
`default_nettype none
module smpp_prog_model (
    // bench side
    input  wire logic        hclk,
    input  wire logic        go,
    input  wire logic [31:0] instr,
    output logic             busy,
    output logic [7:0]       rbyte,
    // link pins
    output logic             prog_sck,
    output logic             prog_data_in,
    input  wire logic        prog_data_out
);
    // link clock stands low between frames
    initial begin
        busy = 1'b0;
        rbyte = 8'h00;
        prog_sck = 1'b0;
        prog_data_in = 1'b0;
    end
    // one frame; byte four is caught just before each fall, where it stands
    always @(posedge go) begin
        busy <= 1'b1;
        for (int i = 31; i >= 0; i--) begin
            prog_data_in <= instr[i];
            repeat (4) @(posedge hclk);
            prog_sck <= 1'b1;
            repeat (4) @(posedge hclk);
            if (i < 8) rbyte <= {rbyte[6:0], prog_data_out};
            prog_sck <= 1'b0;
        end
        repeat (4) @(posedge hclk);
        prog_data_in <= ~instr[0]; // released line shows the inverse
        busy <= 1'b0;
    end
endmodule : smpp_prog_model
`default_nettype wire

/* File: tb/smpp_top_tb_top.sv */
// bench: instructions through the programmer model, status over ahb-lite
// assumes a memory reply one cycle after each strobe
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module smpp_top_tb_top;
    import smpp_pkg::*;
    localparam logic [23:0] SIG = 24'h1248C6; // arbitrary identity values
    logic hclk = 0, hresetn = 0, prog_reset_n = 1, go = 0, hwrite = 0, busy;
    logic prog_sck, prog_data_in, prog_data_out, prog_data_oe, mem_strobe, mem_hi;
    logic [1:0] htrans = 0, startup_delay_fuses;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, instr = 0, q, a, d, rnd = 32'hB028FD89;
    logic hreadyout, hresp;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata, rbyte, m_key = 0;
    smpp_mem_op_t mem_op;
    logic [26:0] log[$];
    int fail_count = 0, num_checks = 0;
    always #50 hclk = ~hclk;
    smpp_top #(.SIG_BYTE0(SIG[23:16]), .SIG_BYTE1(SIG[15:8]), .SIG_BYTE2(SIG[7:0]))
        smpp_top_inst (.hclk, .hresetn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .prog_sck,
        .prog_reset_n, .prog_data_in, .prog_data_out, .prog_data_oe, .mem_strobe, .mem_op,
        .mem_addr, .mem_hi, .mem_wdata, .mem_rdata(m_key ^ 8'hC3), .startup_delay_fuses);
    smpp_prog_model smpp_prog_model_inst (.hclk, .go, .instr, .busy, .rbyte, .prog_sck,
        .prog_data_in, .prog_data_out);
    // memory model: log every strobe, answer from the address next cycle
    always @(posedge hclk) if (mem_strobe === 1'b1) begin
        log.push_back({mem_op, mem_addr, mem_wdata});
        m_key <= mem_addr[7:0];
    end
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : xs
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        int n = 0;
        htrans <= 2'h2;
        haddr <= {24'h0, ad};
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wd;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        q = hrdata;
        if (n >= 50) begin fail_count++; stop_test(); end
    endtask : ahb
    task automatic send(input logic [31:0] v);
        int n = 0;
        instr <= v;
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        @(posedge hclk);
        while (busy === 1'b1 && n < 400) begin @(posedge hclk); n++; end
        if (n >= 400) begin fail_count++; stop_test(); end
    endtask : send
    task automatic pop(input logic [26:0] e, input logic [26:0] m);
        logic [26:0] g;
        g = (log.size() > 0) ? log.pop_front() : ~e;
        `CHK("mem op", e & m, g & m)
    endtask : pop
    // main sequence
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, ADDR_STATUS, 0);
        `CHK("status", 32'h7C, q)
        ahb(0, 8'h08, 0);
        `CHK("unmapped", 32'h0, q)
        ahb(1, ADDR_CTRL, 1);
        ahb(0, ADDR_CTRL, 0);
        `CHK("ctrl", 32'h1, q)
        prog_reset_n <= 1'b0;
        repeat (12) @(posedge hclk);
        d = xs();
        send({OPC_ENTER, OPC_ENABLE, d[15:0]});
        ahb(0, ADDR_STATUS, 0);
        `CHK("status", 32'hFC, q)
        `CHK("oe", 1'b0, prog_data_oe)
        ahb(1, ADDR_CTRL, 0);
        ahb(0, ADDR_CTRL, 0);
        `CHK("ctrl", 32'h0, q)
        `CHK("resp", 1'b0, hresp)
        repeat (12) @(posedge hclk);
        send({OPC_ENTER, OPC_ENABLE, d[31:16]});
        ahb(0, ADDR_STATUS, 0);
        `CHK("status", 32'h7F, q)
        `CHK("oe", 1'b1, prog_data_oe)
        for (int k = 0; k < 3; k++) begin
            d = xs();
            send({OPC_RD_SIG, d[7:0], d[13:8], k[1:0], 8'h00});
            `CHK("signature", SIG[23-8*k -: 8], rbyte)
        end
        send({OPC_RD_FUSE, 24'h0});
        `CHK("fuses", 8'hDF, rbyte)
        a = xs();
        d = xs();
        send({OPC_WR_EE, a[15:0], d[7:0]});
        pop({MEM_WR_EE, 4'h0, a[11:0], d[7:0]}, '1);
        send({OPC_RD_EE, a[15:0], 8'h00});
        pop({MEM_RD_EE, 4'h0, a[11:0], 8'h0}, 27'h7FFFF00);
        `CHK("eeprom", a[7:0] ^ 8'hC3, rbyte)
        send({OPC_RD_FLASH | H_MASK, a[31:16], 8'h00});
        pop({MEM_RD_FLASH, a[31:16], 8'h0}, 27'h7FFFF00);
        `CHK("flash", a[23:16] ^ 8'hC3, rbyte)
        `CHK("half", 1'b1, mem_hi)
        send({OPC_LD_PAGE, a[15:0], d[15:8]});
        pop({MEM_LD_PAGE, 9'h0, a[6:0], d[15:8]}, '1);
        `CHK("half", 1'b0, mem_hi)
        send({OPC_WR_PAGE, a[15:0], d[7:0]});
        pop({MEM_WR_PAGE, a[15:7], 7'h0, 8'h0}, 27'h7FFFF00);
        send({OPC_ENTER, 8'hFD, d[15:0]});
        send({OPC_RD_LOCK, 24'h0});
        `CHK("locks", 8'hFD, rbyte)
        send({OPC_WR_EE, a[15:0], d[7:0]});
        `CHK("refused", 0, log.size())
        send({OPC_ENTER, FUSE_PAT, 4'h4, 16'h0});
        send({OPC_RD_FUSE, 24'h0});
        `CHK("fuses", 8'hDC, rbyte)
        `CHK("startup", 2'h0, startup_delay_fuses)
        send({OPC_ENTER, ERASE_PAT, d[4:0], 16'h0});
        pop({MEM_ERASE_ALL, 24'h0}, 27'h7000000);
        send({OPC_RD_LOCK, 24'h0});
        `CHK("locks", 8'hFF, rbyte)
        send({OPC_RD_FUSE, 24'h0});
        `CHK("fuses", 8'hDC, rbyte)
        send({OPC_ENTER, 8'hB0, 16'h0});
        send({OPC_ENTER, ERASE_PAT, 21'h0});
        pop({MEM_ERASE_FLASH, 24'h0}, 27'h7000000);
        send({OPC_ENTER, 8'hF9, 16'h0});
        send({OPC_RD_FLASH, a[31:16], 8'h00});
        `CHK("verify", 8'hFF, rbyte)
        `CHK("blocked", 0, log.size())
        stop_test();
    end
endmodule : smpp_top_tb_top
`default_nettype wire
